// ### arpms_top.v
`timescale 1ns/1ps
`default_nettype none
`include "arpms_consts.vh"

// Functional notes
// - Byte order high puts the low result byte on d[15:8], else on d[7:0].
// - Output code high presents results in straight binary.
// - Output code low inverts the result MSB for two's complement.
// - Serial/parallel low drives the whole data bus with the result.
// - Serial/parallel high uses some pins as serial port, keeps d[1:0] driven, rest hi-Z.
// - Data bits 0 and 1 are driven as outputs in every mode.
// - Pins 2 to 4 are result outputs only in parallel mode.
// - Serial master read-after-convert samples the divider on d[3:2].
// - Other serial modes keep d[3:2] as high-impedance.
// - Clock source low makes the block master driving the serial clock.
// - Clock source high shifts on an external clock gated by chip select.
// - Divider 00..11 gives serial periods of at least 30/60/120/240 ns.
// - Read-during-convert low waits for conversion end in master mode only, high does not.
// - Serial results are shifted out MSB first.
// - Edge invert low uses rising serial clock edges, high falling.
module arpms_top (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [15:0] result_data,
    input wire result_valid,
    output wire result_ready,
    input wire conv_busy,
    input wire host_read_strobe,
    input wire cs_n,
    input wire [15:0] d_in,
    output reg [15:0] d_out,
    output reg [15:0] d_oe_n,
    output reg word_ready
);
    // ------------------------------------------------------------
    // Local constants
    // ------------------------------------------------------------
    localparam ST_IDLE = 1'b0;
    localparam ST_SHIFT = 1'b1;
    localparam SERIAL_RESULT_OUT_PIN = 8;
    localparam SCLK_PIN = 9;
    localparam DAISY_PIN = 7;
    localparam HALF_0 = `ARPMS_HALF_CYC(`ARPMS_SCLK_MIN_NS_0);
    localparam HALF_1 = `ARPMS_HALF_CYC(`ARPMS_SCLK_MIN_NS_1);
    localparam HALF_2 = `ARPMS_HALF_CYC(`ARPMS_SCLK_MIN_NS_2);
    localparam HALF_3 = `ARPMS_HALF_CYC(`ARPMS_SCLK_MIN_NS_3);
    localparam NBITS = `ARPMS_RESULT_BITS;

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function [15:0] fmt_word;
        input [15:0] w;
        input code;
        input swap;
        reg [15:0] c;
        begin
            c = {w[15] ^ ~code, w[14:0]};
            fmt_word = swap ? {c[7:0], c[15:8]} : c;
        end
    endfunction

    function [7:0] half_cycles;
        input [1:0] div;
        begin
            case (div)
                2'b00: half_cycles = HALF_0[7:0];
                2'b01: half_cycles = HALF_1[7:0];
                2'b10: half_cycles = HALF_2[7:0];
                2'b11: half_cycles = HALF_3[7:0];
                default: half_cycles = HALF_0[7:0];
            endcase
        end
    endfunction

    // ------------------------------------------------------------
    // Registers and wires
    // ------------------------------------------------------------
    reg [`ARPMS_CTRL_WIDTH-1:0] ctrl;
    reg [15:0] last_word;
    reg state;
    reg [15:0] shreg;
    reg [4:0] bit_cnt;
    reg [7:0] half_cnt;
    reg [1:0] div_sel;
    reg sclk_int;
    reg ext_sclk_prev;
    reg [15:0] next_d_out;
    reg [15:0] next_d_oe_n;
    reg [31:0] next_prdata;
    reg next_pslverr;

    wire [15:0] fifo_data;
    wire fifo_valid;
    wire [2:0] fifo_level;
    wire serial_mode;
    wire slave_mode;
    wire read_during_convert_select;
    wire edge_inv;
    wire master_rac;
    wire apb_access;
    wire apb_write;
    wire ser_start;
    wire par_pop;
    wire fifo_pop;
    wire [15:0] fmt_data;
    wire ext_active;
    wire half_done;

    assign serial_mode = ctrl[`ARPMS_CTRL_SERIAL_PARALLEL_SELECT];
    assign slave_mode = ctrl[`ARPMS_CTRL_CLK_SRC];
    assign read_during_convert_select = ctrl[`ARPMS_CTRL_RDC];
    assign edge_inv = ctrl[`ARPMS_CTRL_EDGE_INV];
    assign master_rac = serial_mode & ~slave_mode & ~read_during_convert_select;
    assign fmt_data = fmt_word(fifo_data, ctrl[`ARPMS_CTRL_OUT_CODE],
                               ctrl[`ARPMS_CTRL_BYTE_ORDER] & ~serial_mode);

    // ------------------------------------------------------------
    // Result FIFO
    // ------------------------------------------------------------
    arpms_fifo #(
        .WIDTH(16),
        .DEPTH(`ARPMS_FIFO_DEPTH),
        .AW(2)
    ) u_fifo (
        .clk(pclk),
        .rst_n(presetn),
        .in_data(result_data),
        .in_valid(result_valid),
        .in_ready(result_ready),
        .out_data(fifo_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .level(fifo_level)
    );

    // Parallel: next word only once the host has taken the held one
    assign par_pop = ~serial_mode & fifo_valid &
                     (~word_ready | host_read_strobe);
    // Master read-after-convert waits for the conversion to finish
    assign ser_start = serial_mode & fifo_valid & (state == ST_IDLE) &
                       ~cs_n & (slave_mode | read_during_convert_select | ~conv_busy);
    assign fifo_pop = par_pop | ser_start;

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    // One wait state: answer comes on the second access cycle
    assign apb_access = psel & penable & pready;
    assign apb_write = apb_access & pwrite;

    always @* begin
        next_prdata = 32'h0000_0000;
        next_pslverr = 1'b0;
        case (paddr)
            `ARPMS_OFS_CTRL:
                next_prdata[`ARPMS_CTRL_WIDTH-1:0] = ctrl;
            `ARPMS_OFS_STATUS: begin
                next_prdata[`ARPMS_STAT_WORD_READY] = word_ready;
                next_prdata[`ARPMS_STAT_SHIFTING] = state;
                next_prdata[`ARPMS_STAT_DIV_LO+1:`ARPMS_STAT_DIV_LO] =
                    div_sel;
                next_prdata[`ARPMS_STAT_LEVEL_LO+2:`ARPMS_STAT_LEVEL_LO] =
                    fifo_level;
            end
            `ARPMS_OFS_RESULT:
                next_prdata[15:0] = last_word;
            default:
                next_pslverr = 1'b1;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
            ctrl <= `ARPMS_CTRL_RESET;
        end else begin
            pready <= psel & penable & ~pready;
            if (psel & penable & ~pready) begin
                prdata <= pwrite ? 32'h0000_0000 : next_prdata;
                pslverr <= next_pslverr |
                           (pwrite & (paddr != `ARPMS_OFS_CTRL) &
                            ~next_pslverr);
            end else begin
                prdata <= 32'h0000_0000;
                pslverr <= 1'b0;
            end
            // Mode change mid-shift is allowed but corrupts that word
            if (apb_write & (paddr == `ARPMS_OFS_CTRL))
                ctrl <= pwdata[`ARPMS_CTRL_WIDTH-1:0];
        end
    end

    // ------------------------------------------------------------
    // Parallel word holding
    // ------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            word_ready <= 1'b0;
            last_word <= 16'h0000;
        end else begin
            if (fifo_pop)
                last_word <= fmt_data;
            // New word wins over the host's take in the same cycle
            if (par_pop)
                word_ready <= 1'b1;
            else if (host_read_strobe | serial_mode)
                word_ready <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Serial shifter
    // ------------------------------------------------------------
    // External clock pin is taken as synchronous to pclk
    assign ext_active = edge_inv ? (ext_sclk_prev & ~d_in[SCLK_PIN])
                                 : (~ext_sclk_prev & d_in[SCLK_PIN]);
    assign half_done = (half_cnt == half_cycles(div_sel) - 8'h01);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_IDLE;
            shreg <= 16'h0000;
            bit_cnt <= 5'h00;
            half_cnt <= 8'h00;
            div_sel <= 2'b00;
            sclk_int <= 1'b0;
            ext_sclk_prev <= 1'b0;
        end else begin
            ext_sclk_prev <= d_in[SCLK_PIN];
            case (state)
                ST_IDLE: begin
                    sclk_int <= 1'b0;
                    half_cnt <= 8'h00;
                    bit_cnt <= 5'h00;
                    if (ser_start) begin
                        shreg <= fmt_data;
                        state <= ST_SHIFT;
                        // Divider only read in master read-after-convert
                        if (master_rac)
                            div_sel <= d_in[3:2];
                        else
                            div_sel <= 2'b00;
                    end
                end
                ST_SHIFT: begin
                    if (cs_n | ~serial_mode) begin
                        // Chip select gates the transfer; word is dropped
                        state <= ST_IDLE;
                    end else if (slave_mode) begin
                        if (ext_active) begin
                            shreg <= {shreg[14:0], d_in[DAISY_PIN]};
                            bit_cnt <= bit_cnt + 5'h01;
                            if (bit_cnt == NBITS[4:0] - 5'h01)
                                state <= ST_IDLE;
                        end
                    end else if (half_done) begin
                        half_cnt <= 8'h00;
                        sclk_int <= ~sclk_int;
                        if (~sclk_int) begin
                            bit_cnt <= bit_cnt + 5'h01;
                        end else begin
                            shreg <= {shreg[14:0], 1'b0};
                            if (bit_cnt == NBITS[4:0])
                                state <= ST_IDLE;
                        end
                    end else begin
                        half_cnt <= half_cnt + 8'h01;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    always @* begin
        next_d_out = 16'h0000;
        next_d_oe_n = 16'hffff;
        if (~serial_mode) begin
            next_d_out = last_word;
            next_d_oe_n = 16'h0000;
        end else begin
            // Low bits keep the last word, never float
            next_d_out[1:0] = last_word[1:0];
            next_d_oe_n[1:0] = 2'b00;
            // d[3:2] divider inputs or hi-Z; d[7] daisy input, d[6:4] hi-Z
            next_d_oe_n[7:2] = 6'h3f;
            next_d_out[SERIAL_RESULT_OUT_PIN] = shreg[15];
            next_d_oe_n[SERIAL_RESULT_OUT_PIN] = 1'b0;
            if (~slave_mode) begin
                next_d_out[SCLK_PIN] = sclk_int ^ edge_inv;
                next_d_oe_n[SCLK_PIN] = 1'b0;
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            d_out <= 16'h0000;
            d_oe_n <= 16'hffff;
        end else begin
            d_out <= next_d_out;
            d_oe_n <= next_d_oe_n;
        end
    end
endmodule // arpms_top

`default_nettype wire

// ### arpms_consts.vh
`ifndef ARPMS_CONSTS_VH
`define ARPMS_CONSTS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define ARPMS_OFS_CTRL 12'h000
`define ARPMS_OFS_STATUS 12'h004
`define ARPMS_OFS_RESULT 12'h008

// ----------------------------------------------------------------
// Control field positions and reset value
// ----------------------------------------------------------------
`define ARPMS_CTRL_BYTE_ORDER 0
`define ARPMS_CTRL_OUT_CODE 1
`define ARPMS_CTRL_SERIAL_PARALLEL_SELECT 2
`define ARPMS_CTRL_CLK_SRC 3
`define ARPMS_CTRL_RDC 4
`define ARPMS_CTRL_EDGE_INV 5
`define ARPMS_CTRL_WIDTH 6
`define ARPMS_CTRL_RESET 6'h02

// ----------------------------------------------------------------
// Status field positions
// ----------------------------------------------------------------
`define ARPMS_STAT_WORD_READY 0
`define ARPMS_STAT_SHIFTING 1
`define ARPMS_STAT_DIV_LO 4
`define ARPMS_STAT_LEVEL_LO 8

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define ARPMS_PCLK_NS 50
`define ARPMS_SCLK_MIN_NS_0 30
`define ARPMS_SCLK_MIN_NS_1 60
`define ARPMS_SCLK_MIN_NS_2 120
`define ARPMS_SCLK_MIN_NS_3 240
`define ARPMS_HALF_CYC(ns) (((ns) + 2 * `ARPMS_PCLK_NS - 1) / (2 * `ARPMS_PCLK_NS))
`define ARPMS_RESULT_BITS 16
`define ARPMS_FIFO_DEPTH 4

`endif

// ### arpms_fifo.v
`timescale 1ns/1ps
`default_nettype none

module arpms_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    input wire clk,
    input wire rst_n,
    input wire [WIDTH-1:0] in_data,
    input wire in_valid,
    output reg in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire out_valid,
    input wire out_ready,
    output wire [AW:0] level
);
    // ------------------------------------------------------------
    // Storage and pointers
    // ------------------------------------------------------------
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wptr;
    reg [AW-1:0] rptr;
    reg [AW:0] count;
    wire push;
    wire pop;
    reg [AW:0] next_count;

    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    assign out_valid = (count != {(AW+1){1'b0}});
    assign out_data = mem[rptr];
    assign level = count;

    always @* begin
        next_count = count;
        if (push & ~pop)
            next_count = count + 1'b1;
        else if (pop & ~push)
            next_count = count - 1'b1;
    end

    // Ready is registered so the source sees a clean flop
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wptr <= {AW{1'b0}};
            rptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
            in_ready <= 1'b0;
        end else begin
            count <= next_count;
            in_ready <= (next_count != DEPTH[AW:0]);
            if (push)
                wptr <= (wptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                       : wptr + 1'b1;
            if (pop)
                rptr <= (rptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                       : rptr + 1'b1;
        end
    end

    always @(posedge clk) begin
        if (push)
            mem[wptr] <= in_data;
    end
endmodule // arpms_fifo

`default_nettype wire

// ### arpms_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "arpms_consts.vh"
// ------------------------------
// Port checker
// ------------------------------
module arpms_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic conv_busy,
    input wire logic host_read_strobe,
    input wire logic [15:0] d_out,
    input wire logic [15:0] d_oe_n,
    input wire logic word_ready
);
    // Shadow of the mode bits, aged so the pins may settle
    logic [5:0] ctrl;
    logic [3:0] age;
    logic [3:0] idle;
    logic d9_q;
    logic ser;
    logic mst_rac;
    assign ser = ctrl[`ARPMS_CTRL_SERIAL_PARALLEL_SELECT] && age > 4'h2;
    assign mst_rac = ser && !ctrl[`ARPMS_CTRL_CLK_SRC]
        && !ctrl[`ARPMS_CTRL_RDC];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= `ARPMS_CTRL_RESET;
            age <= 4'h0;
            idle <= 4'h0;
            d9_q <= 1'b0;
        end else begin
            d9_q <= d_out[9];
            if (d_out[9] != d9_q)
                idle <= 4'h0;
            else if (idle != 4'hf)
                idle <= idle + 4'h1;
            if (psel && penable && pready && pwrite && paddr == 12'h000) begin
                ctrl <= pwdata[5:0];
                age <= 4'h0;
            end else if (age != 4'hf) begin
                age <= age + 4'h1;
            end
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence setup_access;
        psel && !penable ##1 psel && penable;
    endsequence
    // Idle clock pin for a while, busy held: no new word may start
    sequence busy_idle;
        (mst_rac && conv_busy && idle > 4'h5) [*4];
    endsequence
    apb_wait_a: assert property (setup_access |-> !pready ##1 pready)
        else $error("apb answer not after one wait state");
    idle_bus_a: assert property (!pready |-> prdata == 32'h0 && !pslverr)
        else $error("apb answer outside the ready cycle");
    bad_access_a: assert property (pready && (paddr > 12'h008
        || (pwrite && paddr != 12'h000)) |-> pslverr)
        else $error("refused access not flagged");
    par_bus_a: assert property (age > 4'h2
        && !ctrl[`ARPMS_CTRL_SERIAL_PARALLEL_SELECT] |-> d_oe_n == 16'h0000)
        else $error("parallel bus not fully driven");
    low_pins_a: assert property (age > 4'h2 |-> d_oe_n[1:0] == 2'b00)
        else $error("low data pins released");
    ser_pins_a: assert property (ser |-> d_oe_n[7:2] == 6'h3f
        && d_oe_n[15:10] == 6'h3f && !d_oe_n[8])
        else $error("serial pin directions wrong");
    clk_dir_a: assert property (ser
        |-> d_oe_n[9] == ctrl[`ARPMS_CTRL_CLK_SRC])
        else $error("serial clock pin direction wrong");
    busy_hold_a: assert property (busy_idle |=> $stable(d_out[9]))
        else $error("word started while converting");
    word_hold_a: assert property (age > 4'h2
        && !ctrl[`ARPMS_CTRL_SERIAL_PARALLEL_SELECT] && word_ready
        && !host_read_strobe |=> word_ready)
        else $error("parallel word dropped unread");
endmodule // arpms_checker
bind arpms_top arpms_checker u_arpms_checker (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .conv_busy(conv_busy),
    .host_read_strobe(host_read_strobe), .d_out(d_out),
    .d_oe_n(d_oe_n), .word_ready(word_ready));
`default_nettype wire

// ### arpms_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// Host reading the results
// ------------------------------
module arpms_host_model (
    input wire logic pclk,
    input wire logic [15:0] d_out,
    input wire logic word_ready,
    output logic host_read_strobe,
    output logic cs_n,
    output logic [15:0] host_drv
);
    localparam logic [15:0] DRV_MASK = 16'h028c;
    logic [15:0] ctl = 16'h0080;
    logic [15:0] noise = 16'h5555;
    initial begin
        host_read_strobe = 1'b0;
        cs_n = 1'b1;
    end
    // Released pins outside DRV_MASK toggle, so a stale level never passes for data
    always @(posedge pclk)
        noise <= ~noise;
    assign host_drv = (noise & ~DRV_MASK) | (ctl & DRV_MASK);
    task automatic take_word(output logic [15:0] w);
        int n;
        n = 0;
        while (word_ready !== 1'b1 && n < 200) begin
            @(posedge pclk);
            n++;
        end
        @(posedge pclk);
        w = d_out;
        host_read_strobe <= 1'b1;
        @(posedge pclk);
        host_read_strobe <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask
    task automatic master_read(input logic inv, output logic [15:0] w,
        output int per);
        int n;
        int k;
        int last;
        logic prev;
        n = 0;
        k = 0;
        last = 0;
        per = 1000;
        w = 16'h0;
        prev = inv;
        cs_n <= 1'b0;
        while (k < 16 && n < 2000) begin
            @(posedge pclk);
            n++;
            if (d_out[9] !== prev && d_out[9] === !inv) begin
                w = {w[14:0], d_out[8]};
                if (k > 0 && n - last < per)
                    per = n - last;
                last = n;
                k++;
            end
            prev = d_out[9];
        end
        repeat (4) @(posedge pclk);
        cs_n <= 1'b1;
    endtask
    // Slow clock, only while selected; bits taken before each edge
    task automatic slave_read(input logic inv, output logic [15:0] w);
        w = 16'h0;
        ctl[9] <= inv;
        cs_n <= 1'b0;
        repeat (6) @(posedge pclk);
        for (int i = 0; i < 16; i++) begin
            w = {w[14:0], d_out[8]};
            ctl[9] <= !inv;
            repeat (4) @(posedge pclk);
            ctl[9] <= inv;
            repeat (4) @(posedge pclk);
        end
        cs_n <= 1'b1;
    endtask
endmodule // arpms_host_model
`default_nettype wire

// ### testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "arpms_consts.vh"
module testbench;
    typedef struct packed {
        logic [5:0] ctrl;
        logic [15:0] raw;
        logic [15:0] exp;
    } arpms_row_t;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [15:0] result_data = 16'h0;
    logic result_valid = 1'b0;
    logic conv_busy = 1'b0;
    wire [31:0] prdata;
    wire pready, pslverr, result_ready, host_read_strobe, cs_n, word_ready;
    wire [15:0] d_in, d_out, d_oe_n, host_drv;
    int err_count = 0;
    int compares = 0;
    int per;
    logic [31:0] rd;
    logic err;
    logic [15:0] w;
    arpms_row_t rows [5] = '{
        '{6'h02, 16'h1234, 16'h1234}, '{6'h00, 16'h1234, 16'h9234},
        '{6'h00, 16'h8001, 16'h0001}, '{6'h03, 16'h00ff, 16'hff00},
        '{6'h01, 16'h7f80, 16'h80ff}};
    int min_ns [4] = '{`ARPMS_SCLK_MIN_NS_0, `ARPMS_SCLK_MIN_NS_1,
        `ARPMS_SCLK_MIN_NS_2, `ARPMS_SCLK_MIN_NS_3};
    always #(`ARPMS_PCLK_NS / 2) pclk = ~pclk;
    // Pin level: the enabled driver wins, otherwise the host
    assign d_in = (d_oe_n & host_drv) | (~d_oe_n & d_out);
    arpms_top u_arpms_top (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .result_data(result_data), .result_valid(result_valid),
        .result_ready(result_ready), .conv_busy(conv_busy),
        .host_read_strobe(host_read_strobe), .cs_n(cs_n), .d_in(d_in),
        .d_out(d_out), .d_oe_n(d_oe_n), .word_ready(word_ready));
    // Host reads the pin level, so an undriven pin shows as such
    arpms_host_model u_arpms_host_model (.pclk(pclk), .d_out(d_in),
        .word_ready(word_ready), .host_read_strobe(host_read_strobe),
        .cs_n(cs_n), .host_drv(host_drv));
    task automatic apb(input logic wr, input logic [11:0] a,
        input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) check(32'(pready), 32'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic push(input logic [15:0] v);
        int n;
        n = 0;
        result_data <= v;
        result_valid <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (result_ready !== 1'b1 && n < 100);
        if (n >= 100) check(32'(result_ready), 32'h1);
        result_valid <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        #(40000 * `ARPMS_PCLK_NS);
        err_count++;
        $display("[FAIL] %0t ns: watchdog expired", $time);
        report_and_stop();
    end
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        foreach (rows[i]) begin
            apb(1'b1, `ARPMS_OFS_CTRL, {26'h0, rows[i].ctrl});
            push(rows[i].raw);
            u_arpms_host_model.take_word(w);
            check(32'(w), 32'(rows[i].exp));
            apb(1'b0, `ARPMS_OFS_RESULT, 32'h0);
            check(rd, 32'(rows[i].exp));
        end
        $display("test parallel rows done");
        // Host stalls while the buffer fills, then drains it
        apb(1'b1, `ARPMS_OFS_CTRL, 32'h2);
        for (int i = 0; i < 5; i++) begin
            push(16'ha000 + 16'(i));
        end
        repeat (2) @(posedge pclk);
        check(32'(result_ready), 32'h0);
        apb(1'b0, `ARPMS_OFS_STATUS, 32'h0);
        check(32'(rd[10:8]), 32'd4);
        for (int i = 0; i < 5; i++) begin
            repeat (3) @(posedge pclk);
            u_arpms_host_model.take_word(w);
            check(32'(w), 32'ha000 + 32'(i));
        end
        apb(1'b0, `ARPMS_OFS_STATUS, 32'h0);
        check(32'(rd[10:8]), 32'd0);
        $display("test buffer fill and drain done");
        for (int d = 0; d < 4; d++) begin
            u_arpms_host_model.ctl[3:2] <= 2'(d);
            apb(1'b1, `ARPMS_OFS_CTRL, {26'h0, d[0], 5'h06});
            push(16'h9c31 ^ 16'(d));
            u_arpms_host_model.master_read(d[0], w, per);
            check(32'(w), 32'(16'h9c31 ^ 16'(d)));
            check(32'(per * `ARPMS_PCLK_NS >= min_ns[d]), 32'h1);
            apb(1'b0, `ARPMS_OFS_STATUS, 32'h0);
            check(32'(rd[5:4]), 32'(d));
        end
        conv_busy <= 1'b1;
        apb(1'b1, `ARPMS_OFS_CTRL, 32'h16);
        push(16'h0f0f);
        u_arpms_host_model.master_read(1'b0, w, per);
        check(32'(w), 32'h0f0f);
        check(32'(per), 32'd2);
        apb(1'b1, `ARPMS_OFS_CTRL, 32'h06);
        push(16'hb00c);
        fork
            u_arpms_host_model.master_read(1'b0, w, per);
            begin
                repeat (20) @(posedge pclk);
                apb(1'b0, `ARPMS_OFS_STATUS, 32'h0);
                check(32'(rd[1]), 32'h0);
                conv_busy <= 1'b0;
            end
        join
        check(32'(w), 32'hb00c);
        $display("test serial master done");
        for (int s = 0; s < 2; s++) begin
            apb(1'b1, `ARPMS_OFS_CTRL, s ? 32'h2e : 32'h0c);
            push(16'hc3a5);
            u_arpms_host_model.slave_read(s[0], w);
            check(32'(w), s ? 32'hc3a5 : 32'h43a5);
        end
        $display("test serial slave done");
        presetn <= 1'b0;
        @(posedge pclk);
        check(32'(d_oe_n), 32'hffff);
        check(32'(word_ready), 32'h0);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        check(32'(d_oe_n), 32'h0000);
        apb(1'b0, `ARPMS_OFS_CTRL, 32'h0);
        check(rd, {26'h0, `ARPMS_CTRL_RESET});
        apb(1'b0, `ARPMS_OFS_STATUS, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, 12'h00c, 32'h0);
        check({rd[30:0], err}, 32'h1);
        apb(1'b1, `ARPMS_OFS_RESULT, 32'hffff);
        check(32'(err), 32'h1);
        apb(1'b1, `ARPMS_OFS_CTRL, 32'hffffffff);
        apb(1'b0, `ARPMS_OFS_CTRL, 32'h0);
        check(rd, 32'h3f);
        $display("test reset and registers done");
        report_and_stop();
    end
endmodule // testbench
`default_nettype wire
